// >>> verilog/ibc_master.sv
// Two-wire master sequencer with arbitration and collision handling
`timescale 1ns/1ns
`include "ibc_regs.svh"

// Functional notes
// [R1] Sending one but reading zero: collision
// [R2] Byte collision: stop, clear full, release
// [R3] Sequence collision: abort, release, clear enable
// [R4] After collision, bus stop sets irq flag
// [R5] New byte always starts at first bit
// [R6] Software claims only a free bus
// [R7] Line low at start: collision, idle
// [R8] Start: SDA high loads divider, counts
// [R9] SCL low in first count: collision
// [R10] SDA low in first count: assert early
// [R11] Else drive SDA, recount, then SCL low
// [R12] Repeated start: SDA low at SCL high
// [R13] SDA falling in count is no collision
// [R14] SCL falling before SDA driven: collision
// [R15] Both high: SDA low, count, SCL low
// [R16] Stop: SDA low, release SCL, sample SDA
// [R17] Stop: SCL low before SDA release
// [R18] Divider holds until SCL reads high
// [R19] Seen bits cleared on reset, disable
// [R20] Reset disables port, ends transfer
// [R21] Collision flag held until software clears
module ibc_master #(
    parameter int RELOAD_W = `IBC_RELOAD_W
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    // Port enable; low parks the sequencer
    input wire logic i_enable,
    // Divider reload value
    input wire logic [RELOAD_W-1:0] i_rate_reload,
    // Shift buffer write strobe and data
    input wire logic i_buf_wr,
    input wire logic [7:0] i_buf_data,
    // Sequence request strobes
    input wire logic i_start_req,
    input wire logic i_rstart_req,
    input wire logic i_stop_req,
    input wire logic i_ack_req,
    // Acknowledge level to send
    input wire logic i_ack_data,
    // Software clears of the sticky flags
    input wire logic i_coll_clr,
    input wire logic i_irq_clr,
    // Open-drain wire sampling
    input wire logic i_sda_in,
    input wire logic i_scl_in,
    // Open-drain drives: enable high pulls low
    output logic o_sda_out,
    output logic o_sda_oe,
    output logic o_scl_out,
    output logic o_scl_oe,
    // Status flags
    output logic o_collision_irq_flag,
    output logic o_serial_port_irq_flag,
    output logic o_buffer_full_flag,
    output logic o_ack_status,
    // Second control register enable bits
    output logic o_start_en,
    output logic o_rstart_en,
    output logic o_stop_en,
    output logic o_ack_en,
    // Bus condition status and sequencer idle
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_idle
);
    // Refuse reload widths beyond the divider
    if (RELOAD_W < 1 || RELOAD_W > 16) begin : g_bad_rw
        $error("ibc_master: RELOAD_W must be 1..16");
    end

    ibc_pkg::ibc_state_t state; // Sequencer state
    logic sda_drv; // Pulling SDA low
    logic scl_drv; // Pulling SCL low
    logic [7:0] shift_buffer_reg; // Outgoing byte
    logic [`IBC_IDX_W-1:0] bit_idx; // Bit in flight
    logic div_load; // Divider reload request
    logic div_zero; // Divider expired
    logic coll_evt; // One-cycle collision pulse
    logic done_evt; // One-cycle completion pulse
    logic coll_watch; // Waiting for stop after loss
    logic stop_pulse; // Stop seen on the bus

    // True when a released line reads low
    function automatic logic lost_one(input logic drv, input logic line);
        lost_one = ~drv & ~line;
    endfunction

    // Lines idle released; output level is always zero
    assign o_sda_out = 1'b0;
    assign o_scl_out = 1'b0;
    assign o_sda_oe = sda_drv;
    assign o_scl_oe = scl_drv;
    assign o_idle = (state == ibc_pkg::IBC_IDLE);

    // Divider reloads on entry to every counted phase; the start check and SCL wait states load it as they leave
    always_comb begin
        div_load = 1'b0;
        case (state)
            ibc_pkg::IBC_IDLE: div_load = i_enable & (i_buf_wr | i_rstart_req | i_ack_req);
            ibc_pkg::IBC_ST_CHECK: div_load = i_sda_in & i_scl_in; // R8
            ibc_pkg::IBC_ST_CNT1: div_load = ~i_sda_in | div_zero; // R10 R11
            ibc_pkg::IBC_RS_SCLW, ibc_pkg::IBC_SP_SCLW,
            ibc_pkg::IBC_TX_SCLW, ibc_pkg::IBC_AK_SCLW: div_load = i_scl_in; // R18
            ibc_pkg::IBC_RS_CNT1, ibc_pkg::IBC_SP_CNT1, ibc_pkg::IBC_TX_HIGH: div_load = div_zero;
            default: div_load = 1'b0;
        endcase
    end

    ibc_rate_div #(
        .W(RELOAD_W)
    ) u_div (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_load(div_load),
        .i_reload(i_rate_reload),
        .o_zero(div_zero)
    );

    ibc_bus_mon u_mon (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_enable(i_enable),
        .i_sda(i_sda_in),
        .i_scl(i_scl_in),
        .o_start_seen(o_start_seen),
        .o_stop_seen(o_stop_seen),
        .o_stop_pulse(stop_pulse)
    );

    // Sequencer: line drives, shifting and enable bits
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state <= ibc_pkg::IBC_IDLE; // R20
            sda_drv <= 1'b0;
            scl_drv <= 1'b0;
            shift_buffer_reg <= 8'h00;
            bit_idx <= '0;
            o_buffer_full_flag <= 1'b0;
            o_ack_status <= 1'b0;
            o_start_en <= 1'b0;
            o_rstart_en <= 1'b0;
            o_stop_en <= 1'b0;
            o_ack_en <= 1'b0;
            coll_evt <= 1'b0;
            done_evt <= 1'b0;
        end else begin
            coll_evt <= 1'b0;
            done_evt <= 1'b0;
            if (!i_enable) begin
                // Disabled: end any transfer, let go of the wire
                state <= ibc_pkg::IBC_IDLE; // R20
                sda_drv <= 1'b0;
                scl_drv <= 1'b0;
                o_buffer_full_flag <= 1'b0;
                o_start_en <= 1'b0;
                o_rstart_en <= 1'b0;
                o_stop_en <= 1'b0;
                o_ack_en <= 1'b0;
            end else begin
                case (state)
                    ibc_pkg::IBC_IDLE: begin
                        // Byte write wins over sequence requests
                        if (i_buf_wr) begin
                            shift_buffer_reg <= i_buf_data;
                            bit_idx <= '0; // R5
                            o_buffer_full_flag <= 1'b1;
                            scl_drv <= 1'b1;
                            sda_drv <= ~i_buf_data[7];
                            state <= ibc_pkg::IBC_TX_LOW;
                        end else if (i_start_req) begin
                            o_start_en <= 1'b1;
                            sda_drv <= 1'b0; // R8
                            scl_drv <= 1'b0;
                            state <= ibc_pkg::IBC_ST_CHECK;
                        end else if (i_rstart_req) begin
                            o_rstart_en <= 1'b1;
                            sda_drv <= 1'b0;
                            state <= ibc_pkg::IBC_RS_CNT0;
                        end else if (i_stop_req) begin
                            o_stop_en <= 1'b1;
                            sda_drv <= 1'b1; // R16
                            state <= ibc_pkg::IBC_SP_SDAW;
                        end else if (i_ack_req) begin
                            o_ack_en <= 1'b1;
                            scl_drv <= 1'b1;
                            sda_drv <= ~i_ack_data;
                            state <= ibc_pkg::IBC_AK_LOW;
                        end
                    end
                    ibc_pkg::IBC_ST_CHECK: begin
                        // Either line already low aborts the start
                        if (!i_sda_in || !i_scl_in) begin
                            coll_evt <= 1'b1; // R7
                        end else begin
                            state <= ibc_pkg::IBC_ST_CNT1; // R8
                        end
                    end
                    ibc_pkg::IBC_ST_CNT1: begin
                        // Another start is racing us; just go early
                        if (!i_sda_in) begin
                            sda_drv <= 1'b1; // R10
                            state <= ibc_pkg::IBC_ST_CNT2;
                        end else if (!i_scl_in) begin
                            coll_evt <= 1'b1; // R9
                        end else if (div_zero) begin
                            sda_drv <= 1'b1; // R11
                            state <= ibc_pkg::IBC_ST_CNT2;
                        end
                    end
                    ibc_pkg::IBC_ST_CNT2: begin
                        // SCL low here is not a loss
                        if (div_zero) begin
                            scl_drv <= 1'b1; // R11
                            o_start_en <= 1'b0;
                            done_evt <= 1'b1;
                            state <= ibc_pkg::IBC_IDLE;
                        end
                    end
                    ibc_pkg::IBC_RS_CNT0: begin
                        // One period with SDA released, SCL low
                        if (div_zero) begin
                            scl_drv <= 1'b0; // R12
                            state <= ibc_pkg::IBC_RS_SCLW;
                        end
                    end
                    ibc_pkg::IBC_RS_SCLW: begin
                        // Sample SDA once SCL is really high
                        if (i_scl_in) begin
                            if (!i_sda_in) begin
                                coll_evt <= 1'b1; // R12
                            end else begin
                                state <= ibc_pkg::IBC_RS_CNT1; // R13
                            end
                        end
                    end
                    ibc_pkg::IBC_RS_CNT1: begin
                        // SDA falling here is tolerated
                        if (!i_scl_in && i_sda_in) begin
                            coll_evt <= 1'b1; // R14
                        end else if (div_zero) begin
                            sda_drv <= 1'b1; // R15
                            state <= ibc_pkg::IBC_RS_CNT2;
                        end
                    end
                    ibc_pkg::IBC_RS_CNT2: begin
                        // SCL goes low regardless of its level
                        if (div_zero) begin
                            scl_drv <= 1'b1; // R15
                            o_rstart_en <= 1'b0;
                            done_evt <= 1'b1;
                            state <= ibc_pkg::IBC_IDLE;
                        end
                    end
                    ibc_pkg::IBC_SP_SDAW: begin
                        // Release SCL once SDA reads low
                        if (!i_sda_in) begin
                            scl_drv <= 1'b0; // R16
                            state <= ibc_pkg::IBC_SP_SCLW;
                        end
                    end
                    ibc_pkg::IBC_SP_SCLW: begin
                        // Slave may stretch; wait for SCL high
                        if (i_scl_in) begin
                            state <= ibc_pkg::IBC_SP_CNT1; // R18
                        end
                    end
                    ibc_pkg::IBC_SP_CNT1: begin
                        // SCL dropping before SDA release loses
                        if (!i_scl_in) begin
                            coll_evt <= 1'b1; // R17
                        end else if (div_zero) begin
                            sda_drv <= 1'b0;
                            state <= ibc_pkg::IBC_SP_CNT2;
                        end
                    end
                    ibc_pkg::IBC_SP_CNT2: begin
                        // Sample SDA one period after release
                        if (div_zero) begin
                            if (!i_sda_in) begin
                                coll_evt <= 1'b1; // R16
                            end else begin
                                o_stop_en <= 1'b0;
                                done_evt <= 1'b1;
                                state <= ibc_pkg::IBC_IDLE;
                            end
                        end
                    end
                    ibc_pkg::IBC_TX_LOW, ibc_pkg::IBC_AK_LOW: begin
                        // Data set up during SCL low
                        if (div_zero) begin
                            scl_drv <= 1'b0;
                            state <= (state == ibc_pkg::IBC_TX_LOW) ?
                                ibc_pkg::IBC_TX_SCLW : ibc_pkg::IBC_AK_SCLW;
                        end
                    end
                    ibc_pkg::IBC_TX_SCLW: begin
                        // Hold the count while SCL is stretched
                        if (i_scl_in) begin
                            state <= ibc_pkg::IBC_TX_HIGH; // R18
                        end
                    end
                    ibc_pkg::IBC_AK_SCLW: begin
                        if (i_scl_in) begin
                            state <= ibc_pkg::IBC_AK_HIGH; // R18
                        end
                    end
                    ibc_pkg::IBC_TX_HIGH: begin
                        // Arbitration only on data bits, not the ack slot
                        if (bit_idx != `IBC_BYTE_BITS &&
                            lost_one(sda_drv, i_sda_in)) begin
                            coll_evt <= 1'b1; // R1
                        end else if (div_zero) begin
                            scl_drv <= 1'b1;
                            if (bit_idx == `IBC_BYTE_BITS) begin
                                // Ack slot over: byte finished
                                o_ack_status <= i_sda_in;
                                o_buffer_full_flag <= 1'b0;
                                sda_drv <= 1'b0;
                                done_evt <= 1'b1;
                                state <= ibc_pkg::IBC_IDLE;
                            end else begin
                                // Next bit, or release for the ack
                                shift_buffer_reg <= {shift_buffer_reg[6:0], 1'b0};
                                bit_idx <= bit_idx + 1'b1;
                                sda_drv <= (bit_idx == `IBC_BYTE_BITS - 1'b1) ?
                                    1'b0 : ~shift_buffer_reg[6];
                                state <= ibc_pkg::IBC_TX_LOW;
                            end
                        end
                    end
                    ibc_pkg::IBC_AK_HIGH: begin
                        // Sending a high ack can lose arbitration
                        if (lost_one(sda_drv, i_sda_in)) begin
                            coll_evt <= 1'b1; // R1
                        end else if (div_zero) begin
                            scl_drv <= 1'b1;
                            o_ack_en <= 1'b0;
                            done_evt <= 1'b1;
                            state <= ibc_pkg::IBC_IDLE;
                        end
                    end
                    default: begin
                        state <= ibc_pkg::IBC_IDLE;
                    end
                endcase
                // Collision overrides: drop everything and let go
                if (next_coll(state)) begin
                    state <= ibc_pkg::IBC_IDLE; // R2
                    sda_drv <= 1'b0; // R2 R3
                    scl_drv <= 1'b0;
                    o_buffer_full_flag <= 1'b0; // R2
                    o_start_en <= 1'b0; // R3
                    o_rstart_en <= 1'b0;
                    o_stop_en <= 1'b0;
                    o_ack_en <= 1'b0;
                end
            end
        end
    end

    // Same-cycle collision test
    function automatic logic next_coll(input ibc_pkg::ibc_state_t st);
        case (st)
            ibc_pkg::IBC_ST_CHECK: next_coll = ~i_sda_in | ~i_scl_in;
            ibc_pkg::IBC_ST_CNT1: next_coll = i_sda_in & ~i_scl_in;
            ibc_pkg::IBC_RS_SCLW: next_coll = i_scl_in & ~i_sda_in;
            ibc_pkg::IBC_RS_CNT1: next_coll = ~i_scl_in & i_sda_in;
            ibc_pkg::IBC_SP_CNT1: next_coll = ~i_scl_in;
            ibc_pkg::IBC_SP_CNT2: next_coll = div_zero & ~i_sda_in;
            ibc_pkg::IBC_TX_HIGH: next_coll = (bit_idx != `IBC_BYTE_BITS) & lost_one(sda_drv, i_sda_in);
            ibc_pkg::IBC_AK_HIGH: next_coll = lost_one(sda_drv, i_sda_in);
            default: next_coll = 1'b0;
        endcase
    endfunction

    // Collision flag: sticky, set beats the software clear
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_collision_irq_flag <= 1'b0;
        end else if (coll_evt) begin
            o_collision_irq_flag <= 1'b1; // R21
        end else if (i_coll_clr) begin
            o_collision_irq_flag <= 1'b0; // R21
        end
    end

    // Keep watching the bus after a loss until a stop
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            coll_watch <= 1'b0;
        end else if (coll_evt) begin
            coll_watch <= 1'b1; // R4
        end else if (stop_pulse || !i_enable) begin
            coll_watch <= 1'b0;
        end
    end

    // Port interrupt flag: completions and post-loss stop
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_serial_port_irq_flag <= 1'b0;
        end else if (done_evt || (coll_watch && stop_pulse)) begin
            o_serial_port_irq_flag <= 1'b1; // R4
        end else if (i_irq_clr) begin
            o_serial_port_irq_flag <= 1'b0;
        end
    end
endmodule

// >>> verilog/ibc_regs.svh
// Constants for the bus-collision aware two-wire master
`ifndef IBC_REGS_SVH
`define IBC_REGS_SVH
// Width of the rate reload field, bits 6:0
`define IBC_RELOAD_W 7
// Bits per byte before the acknowledge slot
`define IBC_BYTE_BITS 4'h8
// Width of the bit index
`define IBC_IDX_W 4
`endif

// >>> verilog/ibc_pkg.sv
// Types shared by the bus-collision aware master
package ibc_pkg;
    // Sequencer states
    typedef enum logic [4:0] {
        IBC_IDLE,
        IBC_ST_CHECK,
        IBC_ST_CNT1,
        IBC_ST_CNT2,
        IBC_RS_CNT0,
        IBC_RS_SCLW,
        IBC_RS_CNT1,
        IBC_RS_CNT2,
        IBC_SP_SDAW,
        IBC_SP_SCLW,
        IBC_SP_CNT1,
        IBC_SP_CNT2,
        IBC_TX_LOW,
        IBC_TX_SCLW,
        IBC_TX_HIGH,
        IBC_AK_LOW,
        IBC_AK_SCLW,
        IBC_AK_HIGH
    } ibc_state_t;
endpackage

// >>> verilog/ibc_rate_div.sv
// Reloadable down counter timing each bus phase
`timescale 1ns/1ns
module ibc_rate_div #(
    parameter int W = 7
) (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_load,
    input wire logic [W-1:0] i_reload,
    output logic o_zero
);
    // Refuse widths the counter cannot serve
    if (W < 1 || W > 16) begin : g_bad_w
        $error("ibc_rate_div: W must be 1..16");
    end

    logic [W-1:0] count; // Remaining ticks

    // Load wins; otherwise run down and rest at zero
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            count <= '0;
        end else if (i_load) begin
            count <= i_reload;
        end else if (count != '0) begin
            count <= count - 1'b1;
        end
    end

    // Same-cycle expiry
    assign o_zero = (count == '0);
endmodule

// >>> verilog/ibc_bus_mon.sv
// Watches the wire for start and stop conditions
`timescale 1ns/1ns
module ibc_bus_mon (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_sda,
    input wire logic i_scl,
    output logic o_start_seen,
    output logic o_stop_seen,
    output logic o_stop_pulse
);
    logic sda_q; // Previous SDA
    logic scl_q; // Previous SCL
    logic start_det; // SDA fell with SCL high
    logic stop_det; // SDA rose with SCL high

    assign start_det = i_scl & scl_q & sda_q & ~i_sda;
    assign stop_det = i_scl & scl_q & ~sda_q & i_sda;

    // Line history; idle bus reads high
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            sda_q <= 1'b1;
            scl_q <= 1'b1;
        end else begin
            sda_q <= i_sda;
            scl_q <= i_scl;
        end
    end

    // Seen bits, cleared when the port is off
    always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_start_seen <= 1'b0; // R19
            o_stop_seen <= 1'b0;
            o_stop_pulse <= 1'b0;
        end else if (!i_enable) begin
            o_start_seen <= 1'b0; // R19
            o_stop_seen <= 1'b0;
            o_stop_pulse <= 1'b0;
        end else begin
            o_stop_pulse <= stop_det;
            if (start_det) begin
                o_start_seen <= 1'b1;
                o_stop_seen <= 1'b0;
            end else if (stop_det) begin
                o_start_seen <= 1'b0;
                o_stop_seen <= 1'b1;
            end
        end
    end
endmodule

// >>> sim/ibc_master_asserts.sv
// Port-level checks for the collision-aware master
`timescale 1ns/1ns
module ibc_master_asserts (
    input wire logic i_mclk,
    input wire logic i_arst_n,
    input wire logic i_enable,
    input wire logic i_start_req,
    input wire logic i_buf_wr,
    input wire logic i_coll_clr,
    input wire logic i_irq_clr,
    input wire logic i_sda_in,
    input wire logic i_scl_in,
    input wire logic o_sda_oe,
    input wire logic o_scl_oe,
    input wire logic o_collision_irq_flag,
    input wire logic o_serial_port_irq_flag,
    input wire logic o_buffer_full_flag,
    input wire logic o_start_en,
    input wire logic o_rstart_en,
    input wire logic o_stop_en,
    input wire logic o_ack_en,
    input wire logic o_start_seen,
    input wire logic o_stop_seen,
    input wire logic o_idle
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_arst_n);
    // Start request accepted; byte write has priority
    sequence start_taken;
        i_start_req && !i_buf_wr && o_idle && i_enable;
    endsequence
    coll_flag_hold_a: assert property (o_collision_irq_flag && !i_coll_clr |=> o_collision_irq_flag)
        else $error("collision flag dropped");
    irq_flag_hold_a: assert property (o_serial_port_irq_flag && !i_irq_clr |=> o_serial_port_irq_flag)
        else $error("port flag dropped");
    coll_release_a: assert property ($rose(o_collision_irq_flag) |->
        $past(!(o_sda_oe || o_scl_oe || o_buffer_full_flag || o_start_en || o_rstart_en || o_stop_en || o_ack_en)))
        else $error("no release on collision");
    start_abort_a: assert property (start_taken ##1 !(i_sda_in && i_scl_in) |-> ##[1:3] o_collision_irq_flag)
        else $error("busy start not flagged");
    start_order_a: assert property ($rose(o_scl_oe) && $past(o_start_en) |-> o_sda_oe)
        else $error("clock pulled before data");
    stop_order_a: assert property ($fell(o_scl_oe) && o_stop_en |-> $past(!i_sda_in))
        else $error("SCL freed too early");
    scl_hold_a: assert property (!o_scl_oe && !i_scl_in && (o_buffer_full_flag || o_ack_en) |=> !o_scl_oe)
        else $error("clock driven while stretched");
    en_off_a: assert property (!i_enable |=> o_idle && !(o_sda_oe || o_scl_oe || o_start_seen || o_stop_seen))
        else $error("disable did not park port");
    stop_irq_a: assert property (o_collision_irq_flag && o_idle && i_scl_in && $past(i_scl_in) && $rose(i_sda_in)
        |-> ##[1:4] o_serial_port_irq_flag) else $error("stop irq missed");
    rs_coll_a: assert property (o_rstart_en && !o_sda_oe && i_scl_in && $past(!i_scl_in) && !i_sda_in
        |=> !o_rstart_en) else $error("restart collision missed");
endmodule
bind ibc_master ibc_master_asserts i_ibc_master_asserts (.*);

// >>> sim/ibc_bus_model.sv
// Shared open-drain wire with pull-ups and a second bus party
`timescale 1ns/1ns
module ibc_bus_model (
    input wire logic i_sda_oe,
    input wire logic i_scl_oe,
    input wire logic i_other_sda_low,
    input wire logic i_other_scl_low,
    output logic o_sda,
    output logic o_scl
);
    // Wired-AND: pull-up wins unless any party pulls low
    assign o_sda = !(i_sda_oe || i_other_sda_low);
    assign o_scl = !(i_scl_oe || i_other_scl_low);
endmodule

// >>> sim/ibc_master_tb.sv
// Self-checking bench for the collision-aware master
`timescale 1ns/1ns
module ibc_master_tb;
    logic clk = 0, rst_n = 0, en = 1, wr = 0, st = 0, rs = 0, sp = 0, cc = 0, ic = 0, ak = 0, osda = 0, oscl = 0;
    logic [7:0] data = 8'h00;
    logic sda, scl, sda_oe, scl_oe, coll, irq, bf, acks, st_en, rs_en, sp_en, ak_en, seen_s, seen_p, idle;
    int fail_count = 0, checked = 0, cyc = 0;
    initial forever #2 clk = ~clk;
    // Other master or slave on the wire
    ibc_bus_model i_ibc_bus_model (.i_sda_oe(sda_oe), .i_scl_oe(scl_oe), .i_other_sda_low(osda),
        .i_other_scl_low(oscl), .o_sda(sda), .o_scl(scl));
    // Short reload keeps phases at four cycles
    ibc_master i_ibc_master (.i_mclk(clk), .i_arst_n(rst_n), .i_enable(en), .i_rate_reload(7'h03),
        .i_buf_wr(wr), .i_buf_data(data), .i_start_req(st), .i_rstart_req(rs), .i_stop_req(sp),
        .i_ack_req(ak), .i_ack_data(1'b0), .i_coll_clr(cc), .i_irq_clr(ic), .i_sda_in(sda),
        .i_scl_in(scl), .o_sda_out(), .o_sda_oe(sda_oe), .o_scl_out(), .o_scl_oe(scl_oe),
        .o_collision_irq_flag(coll), .o_serial_port_irq_flag(irq), .o_buffer_full_flag(bf),
        .o_ack_status(acks), .o_start_en(st_en), .o_rstart_en(rs_en), .o_stop_en(sp_en), .o_ack_en(ak_en),
        .o_start_seen(seen_s), .o_stop_seen(seen_p), .o_idle(idle));
    task automatic chk(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %0t got %b expected %b", $time, got, exp);
        end
    endtask
    // Pulse: 0 byte, 1 start, 2 rstart, 3 stop, 4 coll clear, 5 irq clear, 6 ack
    task automatic req(input int k, input logic [7:0] d);
        @(negedge clk);
        {wr, st, rs, sp, cc, ic, ak} = 7'h40 >> k;
        data = d;
        @(negedge clk);
        {wr, st, rs, sp, cc, ic, ak} = 7'h00;
    endtask
    // Bounded wait, then flags settle
    task automatic wait_idle;
        for (int i = 0; i < 400 && !idle; i++) @(negedge clk);
        repeat (3) @(negedge clk);
    endtask
    task automatic clr;
        req(4, 8'h00);
        req(5, 8'h00);
    endtask
    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
        // Plain start, then stop
        req(1, 8'h00);
        chk(st_en, 1'b1);
        wait_idle;
        chk(sda_oe & scl_oe & irq, 1'b1);
        clr;
        req(3, 8'h00);
        chk(sp_en, 1'b1);
        wait_idle;
        chk(sda_oe | scl_oe | coll, 1'b0);
        chk(seen_p & irq, 1'b1);
        $display("start and stop done");
        // Data line held low: lose arbitration at bit 5
        clr;
        osda = 1'b1;
        req(0, 8'h20);
        chk(bf, 1'b1);
        wait_idle;
        chk(coll, 1'b1);
        chk(bf | sda_oe | scl_oe, 1'b0);
        osda = 1'b0;
        repeat (4) @(negedge clk);
        chk(irq & coll, 1'b1);
        clr;
        chk(coll, 1'b0);
        $display("byte collision done");
        // New byte starts from bit 7; clock stretched meanwhile
        req(0, 8'h7F);
        chk(sda_oe, 1'b1);
        oscl = 1'b1;
        repeat (10) @(negedge clk);
        chk(scl_oe, 1'b0);
        oscl = 1'b0;
        wait_idle;
        chk(acks & ~bf & ~coll, 1'b1);
        $display("restart byte done");
        // Repeated start against a low data line
        clr;
        osda = 1'b1;
        req(2, 8'h00);
        chk(rs_en, 1'b1);
        wait_idle;
        chk(coll, 1'b1);
        chk(rs_en | sda_oe | scl_oe, 1'b0);
        osda = 1'b0;
        $display("repeated start done");
        // Start with clock already low
        clr;
        oscl = 1'b1;
        req(1, 8'h00);
        wait_idle;
        chk(coll, 1'b1);
        chk(st_en | sda_oe, 1'b0);
        oscl = 1'b0;
        $display("busy start done");
        // Disable parks the port and clears seen bits
        chk(seen_p, 1'b1);
        en = 1'b0;
        repeat (2) @(negedge clk);
        chk(seen_p | seen_s, 1'b0);
        chk(idle, 1'b1);
        en = 1'b1;
        // Acknowledge sequence on a free bus
        clr;
        req(6, 8'h00);
        chk(ak_en, 1'b1);
        wait_idle;
        chk(irq & ~ak_en & ~coll, 1'b1);
        $display("disable and ack done");
        end_sim();
    end
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            end_sim();
        end
    end
endmodule
